/* File: core/ref_input_select_regs.sv */
`timescale 1ns/100ps
`include "ref_sel_defines.svh"
module ref_input_select_regs #(
  parameter int ADDR_W = 12
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [ADDR_W-1:0] i_awaddr,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [ADDR_W-1:0] i_araddr,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  input wire logic [1:0] i_ref_select_pin,
  input wire logic i_primary_usable,
  output logic [1:0] o_status_b_edge_rate,
  output logic [1:0] o_status_a_edge_rate,
  output logic [1:0] o_secondary_buffer_mode,
  output logic [1:0] o_primary_buffer_mode,
  output logic [1:0] o_synth2_ref_policy,
  output logic o_synth2_use_secondary,
  output logic o_synth2_auto_mode
);

  // address decode shared by both channels
  function automatic ref_sel_pkg::reg_sel_t reg_decode(input logic [ADDR_W-1:0] addr);
    logic [9:0] idx;
    idx = 10'(addr[ADDR_W-1:2]);
    if (addr[1:0] != 2'b00) begin
      reg_decode = ref_sel_pkg::SEL_NONE;
    end else if (idx == `RSR_SLEW_IDX) begin
      reg_decode = ref_sel_pkg::SEL_SLEW;
    end else if (idx == `RSR_INSEL_IDX) begin
      reg_decode = ref_sel_pkg::SEL_INSEL;
    end else if (idx == `RSR_STAT_IDX) begin
      reg_decode = ref_sel_pkg::SEL_STAT;
    end else begin
      reg_decode = ref_sel_pkg::SEL_NONE;
    end
  endfunction

  ref_sel_pkg::cfg_t cfg_r;
  ref_sel_pkg::cfg_t cfg_nxt;
  ref_sel_pkg::route_t route_r;
  ref_sel_pkg::route_t route_now;

  ref_sel_pkg::wr_state_t wr_state_r;
  ref_sel_pkg::wr_state_t wr_state_nxt;
  logic aw_have_r;
  logic aw_have_nxt;
  logic w_have_r;
  logic w_have_nxt;
  logic [ADDR_W-1:0] aw_addr_r;
  logic [ADDR_W-1:0] aw_addr_nxt;
  logic [7:0] w_byte_r;
  logic [7:0] w_byte_nxt;
  logic w_lane_r;
  logic w_lane_nxt;
  logic [1:0] bresp_r;
  logic [1:0] bresp_nxt;

  ref_sel_pkg::rd_state_t rd_state_r;
  ref_sel_pkg::rd_state_t rd_state_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic [1:0] rresp_r;
  logic [1:0] rresp_nxt;

  logic [1:0] pin_s1_r;
  logic [1:0] pin_s2_r;
  logic pri_s1_r;
  logic pri_s2_r;

  // pin synchronisers
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      pin_s1_r <= 2'h0;
      pin_s2_r <= 2'h0;
      pri_s1_r <= 1'b0;
      pri_s2_r <= 1'b0;
    end else begin
      pin_s1_r <= i_ref_select_pin;
      pin_s2_r <= pin_s1_r;
      pri_s1_r <= i_primary_usable;
      pri_s2_r <= pri_s1_r;
    end
  end

  ref_policy_resolve u_resolve (
    .i_policy(cfg_r.synth2_ref_policy),
    .i_pin_level(ref_sel_pkg::pin_level_t'(pin_s2_r)),
    .i_primary_usable(pri_s2_r),
    .o_route(route_now)
  );

  // write channel
  assign o_awready = (wr_state_r == ref_sel_pkg::WR_COLLECT) && !aw_have_r;
  assign o_wready = (wr_state_r == ref_sel_pkg::WR_COLLECT) && !w_have_r;
  assign o_bvalid = (wr_state_r == ref_sel_pkg::WR_RESP);
  assign o_bresp = bresp_r;

  always_comb begin
    wr_state_nxt = wr_state_r;
    aw_have_nxt = aw_have_r;
    w_have_nxt = w_have_r;
    aw_addr_nxt = aw_addr_r;
    w_byte_nxt = w_byte_r;
    w_lane_nxt = w_lane_r;
    bresp_nxt = bresp_r;
    cfg_nxt = cfg_r;
    case (wr_state_r)
      ref_sel_pkg::WR_COLLECT: begin
        if (i_awvalid && o_awready) begin
          aw_have_nxt = 1'b1;
          aw_addr_nxt = i_awaddr;
        end
        if (i_wvalid && o_wready) begin
          w_have_nxt = 1'b1;
          w_byte_nxt = i_wdata[7:0];
          w_lane_nxt = i_wstrb[0];
        end
        if (aw_have_nxt && w_have_nxt) begin
          wr_state_nxt = ref_sel_pkg::WR_COMMIT;
        end
      end
      ref_sel_pkg::WR_COMMIT: begin
        aw_have_nxt = 1'b0;
        w_have_nxt = 1'b0;
        bresp_nxt = `RSR_RESP_OKAY;
        wr_state_nxt = ref_sel_pkg::WR_RESP;
        case (reg_decode(aw_addr_r))
          ref_sel_pkg::SEL_SLEW: begin
            if (w_lane_r) begin
              cfg_nxt.status_b_edge_rate = w_byte_r[`RSR_SLEW_B_HI:`RSR_SLEW_B_LO];
              cfg_nxt.status_a_edge_rate = w_byte_r[`RSR_SLEW_A_HI:`RSR_SLEW_A_LO];
            end
          end
          ref_sel_pkg::SEL_INSEL: begin
            if (w_lane_r) begin
              cfg_nxt.secondary_buffer_mode = w_byte_r[`RSR_SEC_HI:`RSR_SEC_LO];
              cfg_nxt.primary_buffer_mode = w_byte_r[`RSR_PRI_HI:`RSR_PRI_LO];
              cfg_nxt.synth2_ref_policy =
                ref_sel_pkg::policy_t'(w_byte_r[`RSR_POL_HI:`RSR_POL_LO]);
            end
          end
          ref_sel_pkg::SEL_STAT: begin
            bresp_nxt = `RSR_RESP_OKAY;
          end
          default: begin
            bresp_nxt = `RSR_RESP_SLVERR;
          end
        endcase
      end
      default: begin
        if (i_bready) begin
          wr_state_nxt = ref_sel_pkg::WR_COLLECT;
        end
      end
    endcase
  end

  // read channel
  assign o_arready = (rd_state_r == ref_sel_pkg::RD_IDLE);
  assign o_rvalid = (rd_state_r == ref_sel_pkg::RD_RESP);
  assign o_rdata = rdata_r;
  assign o_rresp = rresp_r;

  always_comb begin
    rd_state_nxt = rd_state_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    case (rd_state_r)
      ref_sel_pkg::RD_IDLE: begin
        if (i_arvalid) begin
          rd_state_nxt = ref_sel_pkg::RD_RESP;
          rdata_nxt = `RSR_WORD_ZERO;
          rresp_nxt = `RSR_RESP_OKAY;
          case (reg_decode(i_araddr))
            ref_sel_pkg::SEL_SLEW: begin
              rdata_nxt[`RSR_SLEW_B_HI:`RSR_SLEW_B_LO] = cfg_r.status_b_edge_rate;
              rdata_nxt[`RSR_SLEW_A_HI:`RSR_SLEW_A_LO] = cfg_r.status_a_edge_rate;
            end
            ref_sel_pkg::SEL_INSEL: begin
              rdata_nxt[`RSR_SEC_HI:`RSR_SEC_LO] = cfg_r.secondary_buffer_mode;
              rdata_nxt[`RSR_PRI_HI:`RSR_PRI_LO] = cfg_r.primary_buffer_mode;
              rdata_nxt[`RSR_POL_HI:`RSR_POL_LO] = cfg_r.synth2_ref_policy;
            end
            ref_sel_pkg::SEL_STAT: begin
              rdata_nxt[`RSR_STAT_USE_SEC] = route_r.use_secondary;
              rdata_nxt[`RSR_STAT_AUTO] = route_r.auto_mode;
              rdata_nxt[`RSR_STAT_PRI_OK] = pri_s2_r;
              rdata_nxt[`RSR_STAT_PIN_HI:`RSR_STAT_PIN_LO] = pin_s2_r;
            end
            default: begin
              rresp_nxt = `RSR_RESP_SLVERR;
            end
          endcase
        end
      end
      default: begin
        if (i_rready) begin
          rd_state_nxt = ref_sel_pkg::RD_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      cfg_r.status_b_edge_rate <= `RSR_SLEW_RST;
      cfg_r.status_a_edge_rate <= `RSR_SLEW_RST;
      cfg_r.secondary_buffer_mode <= `RSR_SEC_RST;
      cfg_r.primary_buffer_mode <= `RSR_PRI_RST;
      cfg_r.synth2_ref_policy <= ref_sel_pkg::policy_t'(`RSR_POL_RST);
      route_r <= '0;
      wr_state_r <= ref_sel_pkg::WR_COLLECT;
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      aw_addr_r <= '0;
      w_byte_r <= 8'h00;
      w_lane_r <= 1'b0;
      bresp_r <= `RSR_RESP_OKAY;
      rd_state_r <= ref_sel_pkg::RD_IDLE;
      rdata_r <= `RSR_WORD_ZERO;
      rresp_r <= `RSR_RESP_OKAY;
    end else begin
      cfg_r <= cfg_nxt;
      route_r <= route_now;
      wr_state_r <= wr_state_nxt;
      aw_have_r <= aw_have_nxt;
      w_have_r <= w_have_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_byte_r <= w_byte_nxt;
      w_lane_r <= w_lane_nxt;
      bresp_r <= bresp_nxt;
      rd_state_r <= rd_state_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  // configuration and routing outputs
  assign o_status_b_edge_rate = cfg_r.status_b_edge_rate;
  assign o_status_a_edge_rate = cfg_r.status_a_edge_rate;
  assign o_secondary_buffer_mode = cfg_r.secondary_buffer_mode;
  assign o_primary_buffer_mode = cfg_r.primary_buffer_mode;
  assign o_synth2_ref_policy = cfg_r.synth2_ref_policy;
  assign o_synth2_use_secondary = route_r.use_secondary;
  assign o_synth2_auto_mode = route_r.auto_mode;

endmodule // ref_input_select_regs

/* File: core/ref_sel_defines.svh */
`ifndef REF_SEL_DEFINES_SVH
`define REF_SEL_DEFINES_SVH

`define RSR_SLEW_IDX 10'h031
`define RSR_INSEL_IDX 10'h032
`define RSR_STAT_IDX 10'h033

`define RSR_SLEW_B_HI 3
`define RSR_SLEW_B_LO 2
`define RSR_SLEW_A_HI 1
`define RSR_SLEW_A_LO 0
`define RSR_SEC_HI 7
`define RSR_SEC_LO 6
`define RSR_PRI_HI 5
`define RSR_PRI_LO 4
`define RSR_POL_HI 3
`define RSR_POL_LO 2

`define RSR_STAT_USE_SEC 0
`define RSR_STAT_AUTO 1
`define RSR_STAT_PRI_OK 2
`define RSR_STAT_PIN_HI 5
`define RSR_STAT_PIN_LO 4

`define RSR_SLEW_RST 2'h0
`define RSR_SEC_RST 2'h2
`define RSR_PRI_RST 2'h1
`define RSR_POL_RST 2'h1

`define RSR_RESP_OKAY 2'h0
`define RSR_RESP_SLVERR 2'h2
`define RSR_WORD_ZERO 32'h0000_0000

`endif

/* File: core/ref_sel_pkg.sv */
package ref_sel_pkg;

  typedef enum logic [1:0] {
    POL_AUTO = 2'h0,
    POL_PIN = 2'h1,
    POL_PRI = 2'h2,
    POL_SEC = 2'h3
  } policy_t;

  typedef enum logic [1:0] {
    LVL_LOW = 2'h0,
    LVL_MID = 2'h1,
    LVL_HIGH = 2'h2,
    LVL_BAD = 2'h3
  } pin_level_t;

  typedef enum logic [1:0] {
    SEL_SLEW = 2'h0,
    SEL_INSEL = 2'h1,
    SEL_STAT = 2'h2,
    SEL_NONE = 2'h3
  } reg_sel_t;

  typedef enum logic [1:0] {
    WR_COLLECT = 2'b00,
    WR_COMMIT = 2'b01,
    WR_RESP = 2'b11
  } wr_state_t;

  typedef enum logic {
    RD_IDLE = 1'b0,
    RD_RESP = 1'b1
  } rd_state_t;

  typedef struct packed {
    logic [1:0] status_b_edge_rate;
    logic [1:0] status_a_edge_rate;
    logic [1:0] secondary_buffer_mode;
    logic [1:0] primary_buffer_mode;
    policy_t synth2_ref_policy;
  } cfg_t;

  typedef struct packed {
    logic use_secondary;
    logic auto_mode;
  } route_t;

endpackage

/* File: core/ref_policy_resolve.sv */
`timescale 1ns/100ps
module ref_policy_resolve (
  input wire ref_sel_pkg::policy_t i_policy,
  input wire ref_sel_pkg::pin_level_t i_pin_level,
  input wire logic i_primary_usable,
  output ref_sel_pkg::route_t o_route
);

  always_comb begin
    o_route.use_secondary = 1'b0;
    o_route.auto_mode = 1'b0;
    case (i_policy)
      ref_sel_pkg::POL_AUTO: begin
        o_route.auto_mode = 1'b1;
        o_route.use_secondary = !i_primary_usable;
      end
      ref_sel_pkg::POL_PIN: begin
        if (i_pin_level == ref_sel_pkg::LVL_LOW) begin
          o_route.use_secondary = 1'b1;
        end else begin
          o_route.auto_mode = 1'b1;
          o_route.use_secondary = !i_primary_usable;
        end
      end
      ref_sel_pkg::POL_PRI: begin
        o_route.use_secondary = 1'b0;
      end
      default: begin
        o_route.use_secondary = 1'b1;
      end
    endcase
  end

endmodule // ref_policy_resolve

/* File: sim/ref_input_select_regs_asserts.sv */
`timescale 1ns/100ps
module ref_input_select_regs_asserts #(
  parameter int ADDR_W = 12
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_awvalid,
  input wire logic o_awready,
  input wire logic i_wvalid,
  input wire logic o_wready,
  input wire logic o_bvalid,
  input wire logic i_arvalid,
  input wire logic o_arready,
  input wire logic [ADDR_W-1:0] i_araddr,
  input wire logic [31:0] o_rdata,
  input wire logic [1:0] i_ref_select_pin,
  input wire logic i_primary_usable,
  input wire logic [1:0] o_status_b_edge_rate,
  input wire logic [1:0] o_status_a_edge_rate,
  input wire logic [1:0] o_secondary_buffer_mode,
  input wire logic [1:0] o_primary_buffer_mode,
  input wire logic [1:0] o_synth2_ref_policy,
  input wire logic o_synth2_use_secondary,
  input wire logic o_synth2_auto_mode
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  a_pin_low_sec: assert property (
    (o_synth2_ref_policy == 2'h1 && i_ref_select_pin == 2'h0)[*4]
    |-> o_synth2_use_secondary && !o_synth2_auto_mode) else $error("pin low route");
  a_pin_high_auto: assert property (
    (o_synth2_ref_policy == 2'h1 && i_ref_select_pin != 2'h0)[*4]
    |-> o_synth2_auto_mode) else $error("pin high route");
  a_auto_pri: assert property (
    (o_synth2_ref_policy == 2'h0 && i_primary_usable)[*4]
    |-> !o_synth2_use_secondary && o_synth2_auto_mode) else $error("auto route");
  a_forced_pri: assert property ((o_synth2_ref_policy == 2'h2)[*3]
    |-> !o_synth2_use_secondary && !o_synth2_auto_mode) else $error("forced primary");
  a_forced_sec: assert property ((o_synth2_ref_policy == 2'h3)[*3]
    |-> o_synth2_use_secondary && !o_synth2_auto_mode) else $error("forced secondary");
  a_write_resp: assert property (
    i_awvalid && o_awready && i_wvalid && o_wready |-> ##2 o_bvalid) else $error("late bvalid");
  a_cfg_hold: assert property (!$rose(o_bvalid) |-> $stable({o_status_b_edge_rate,
    o_status_a_edge_rate, o_secondary_buffer_mode, o_primary_buffer_mode,
    o_synth2_ref_policy})) else $error("cfg moved");
  a_slew_rsvd: assert property (
    i_arvalid && o_arready && i_araddr == 12'h0c4 |=> o_rdata[31:4] == 28'h0)
    else $error("slew upper bits");
endmodule // ref_input_select_regs_asserts

/* File: sim/ref_input_select_regs_test.sv */
`timescale 1ns/100ps
module ref_input_select_regs_test;
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  logic i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0, i_arvalid = 1'b0, i_rready = 1'b0;
  logic [11:0] i_awaddr = 12'h000, i_araddr = 12'h000;
  logic [31:0] i_wdata = 32'h0;
  logic [3:0] i_wstrb = 4'h1;
  logic [1:0] i_ref_select_pin = 2'h0;
  logic i_primary_usable = 1'b1;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic o_synth2_use_secondary, o_synth2_auto_mode;
  logic [1:0] o_bresp, o_rresp, o_status_b_edge_rate, o_status_a_edge_rate;
  logic [1:0] o_secondary_buffer_mode, o_primary_buffer_mode, o_synth2_ref_policy;
  logic [31:0] o_rdata, rd_v;
  logic [1:0] rsp, pp, lv;
  logic u, auto_e, sec_e;
  int err_total = 0;
  int comparisons = 0;
  always #5 i_clk = ~i_clk;
  ref_input_select_regs #(.ADDR_W(12)) dut (.i_clk, .i_reset, .i_awvalid, .o_awready,
    .i_awaddr, .i_wvalid, .o_wready, .i_wdata, .i_wstrb, .o_bvalid, .i_bready, .o_bresp,
    .i_arvalid, .o_arready, .i_araddr, .o_rvalid, .i_rready, .o_rdata, .o_rresp,
    .i_ref_select_pin, .i_primary_usable, .o_status_b_edge_rate, .o_status_a_edge_rate,
    .o_secondary_buffer_mode, .o_primary_buffer_mode, .o_synth2_ref_policy,
    .o_synth2_use_secondary, .o_synth2_auto_mode);
  task close_out();
    $display("errors %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("wrong value at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task hang();
    err_total++;
    $display("wrong value at %0t: no answer", $time);
    close_out();
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clk);
    i_awvalid <= 1'b1;
    i_awaddr <= a;
    i_wvalid <= 1'b1;
    i_wdata <= d;
    i_bready <= 1'b1;
    do begin
      @(posedge i_clk);
      n++;
      if (o_awready) i_awvalid <= 1'b0;
      if (o_wready) i_wvalid <= 1'b0;
    end while (!o_bvalid && n < 40);
    if (!o_bvalid) hang();
    rsp = o_bresp;
    i_bready <= 1'b0;
  endtask
  task rd(input logic [11:0] a);
    int n;
    n = 0;
    @(posedge i_clk);
    i_arvalid <= 1'b1;
    i_araddr <= a;
    i_rready <= 1'b1;
    do begin
      @(posedge i_clk);
      n++;
      if (o_arready) i_arvalid <= 1'b0;
    end while (!o_rvalid && n < 40);
    if (!o_rvalid) hang();
    rd_v = o_rdata;
    rsp = o_rresp;
    i_rready <= 1'b0;
  endtask
  initial begin
    repeat (4) @(posedge i_clk);
    i_reset <= 1'b0;
    chk(32'(o_secondary_buffer_mode), 32'h2);
    chk(32'(o_primary_buffer_mode), 32'h1);
    chk(32'(o_synth2_ref_policy), 32'h1);
    chk(32'({o_status_b_edge_rate, o_status_a_edge_rate}), 32'h0);
    rd(12'h0c8);
    chk(rd_v, 32'h94);
    wr(12'h0cc, 32'hff);
    chk(32'(rsp), 32'h0);
    wr(12'h100, 32'hff);
    chk(32'(rsp), 32'h2);
    i_wstrb <= 4'h0;
    wr(12'h0c8, 32'h00);
    chk(32'(rsp), 32'h0);
    i_wstrb <= 4'h1;
    rd(12'h0c8);
    chk(rd_v, 32'h94);
    rd(12'h0c5);
    chk(32'(rsp), 32'h2);
    wr(12'h0c4, 32'hfa);
    chk(32'(rsp), 32'h0);
    rd(12'h0c4);
    chk(rd_v, 32'h0a);
    wr(12'h0c4, 32'h02);
    chk(32'(o_status_b_edge_rate), 32'h0);
    chk(32'(o_status_a_edge_rate), 32'h2);
    rd(12'h100);
    chk(32'(rsp), 32'h2);
    for (int p = 0; p < 4; p++) begin
      pp = p[1:0];
      wr(12'h0c8, {24'h0, pp, ~pp, pp, 2'h0});
      chk(32'(o_secondary_buffer_mode), 32'(pp));
      chk(32'(o_primary_buffer_mode), 32'(2'h3 - pp));
      chk(32'(o_synth2_ref_policy), 32'(pp));
      for (int l = 0; l < 6; l++) begin
        lv = 2'(l / 2);
        u = l[0];
        @(posedge i_clk);
        i_ref_select_pin <= lv;
        i_primary_usable <= u;
        repeat (5) @(posedge i_clk);
        auto_e = pp == 2'h0 || (pp == 2'h1 && lv != 2'h0);
        sec_e = pp == 2'h3 || (pp == 2'h1 && lv == 2'h0) || (auto_e && !u);
        chk(32'(o_synth2_use_secondary), 32'(sec_e));
        chk(32'(o_synth2_auto_mode), 32'(auto_e));
        rd(12'h0cc);
        chk(rd_v, {26'h0, lv, 1'b0, u, auto_e, sec_e});
      end
    end
    close_out();
  end
endmodule // ref_input_select_regs_test
bind ref_input_select_regs ref_input_select_regs_asserts #(.ADDR_W(ADDR_W)) u_chk (.i_clk,
  .i_reset, .i_awvalid, .o_awready, .i_wvalid, .o_wready, .o_bvalid, .i_arvalid, .o_arready,
  .i_araddr, .o_rdata, .i_ref_select_pin, .i_primary_usable, .o_status_b_edge_rate,
  .o_status_a_edge_rate, .o_secondary_buffer_mode, .o_primary_buffer_mode,
  .o_synth2_ref_policy, .o_synth2_use_secondary, .o_synth2_auto_mode);
